// ### rtl/spw_top.sv
`timescale 1ns/1ns
`include "spw_defs.svh"
module spw_top (
  input  wire logic              ref_clk,
  input  wire logic              rst,
  input  wire logic              ce,
  // AXI4-Lite write address
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire spw_pkg::spw_addr_t s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  input  wire spw_pkg::spw_data_t s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // AXI4-Lite write response
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output logic [1:0]             s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  input  wire spw_pkg::spw_addr_t s_axi_araddr,
  // AXI4-Lite read data
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output spw_pkg::spw_data_t     s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  // Block outputs
  output spw_pkg::spw_page_t     active_page,
  output logic [3:0]             clock_n_divider,
  output logic                   clock_k_divider,
  output logic                   watchdog_enable_bit,
  output logic                   power_down_enable,
  output logic                   slow_down_enable,
  output logic                   prot_locked
);
  import spw_pkg::*;

  // Bus holding registers
  logic      awready_r;
  logic      wready_r;
  logic      bvalid_r;
  logic [1:0] bresp_r;
  logic      arready_r;
  logic      rvalid_r;
  spw_data_t rdata_r;
  logic [1:0] rresp_r;
  logic      aw_hold_r;
  logic      w_hold_r;
  spw_addr_t awaddr_r;
  spw_byte_t wdata_r;
  logic      wstrb0_r;

  // Block state
  spw_page_t page_r;
  spw_page_t slot_r [4];
  spw_byte_t prot_r;

  // Decoded write strobes and fields, and the read mux results
  logic      commit;
  logic      wr_hit;
  logic      wr_page;
  logic      wr_pw;
  logic      wr_prot;
  logic [1:0] pg_op;
  logic [1:0] nr;
  spw_data_t rd_nxt;
  logic [1:0] rresp_nxt;

  spw_gate_if gif ();

  spw_gate u_gate (
    .ref_clk (ref_clk),
    .rst     (rst),
    .ce      (ce),
    .g       (gif.gate)
  );

  // Port drives, all from flip-flops
  assign s_axi_awready       = awready_r;
  assign s_axi_wready        = wready_r;
  assign s_axi_bvalid        = bvalid_r;
  assign s_axi_bresp         = bresp_r;
  assign s_axi_arready       = arready_r;
  assign s_axi_rvalid        = rvalid_r;
  assign s_axi_rdata         = rdata_r;
  assign s_axi_rresp         = rresp_r;
  assign active_page         = page_r;
  assign clock_n_divider     = prot_r[3:`SPW_NDIVIDER_LSB];
  assign clock_k_divider     = prot_r[`SPW_KDIVIDER_BIT];
  assign watchdog_enable_bit = prot_r[`SPW_WDT_BIT];
  assign power_down_enable   = prot_r[`SPW_PWRDN_BIT];
  assign slow_down_enable    = prot_r[`SPW_SLOWDN_BIT];
  assign prot_locked         = gif.locked;

  // A write happens once both halves are held and the last response is gone
  assign commit  = aw_hold_r && w_hold_r && !bvalid_r;
  assign wr_hit  = commit && wstrb0_r; // Only byte lane 0 carries data
  assign wr_page = wr_hit && awaddr_r == `SPW_PAGE_OFF;
  assign wr_pw   = wr_hit && awaddr_r == `SPW_PW_OFF;
  assign wr_prot = wr_hit && awaddr_r == `SPW_PROT_OFF;
  assign pg_op   = wdata_r[7:`SPW_PGOP_LSB];
  assign nr      = wdata_r[5:`SPW_SLOT_LSB];

  assign gif.wr    = wr_pw;
  assign gif.wdata = wdata_r;

  // Write address channel; ready drops while a write is held or answered
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      awready_r <= 1'b0;
      aw_hold_r <= 1'b0;
      awaddr_r  <= 4'h0;
    end else if (ce) begin
      if (s_axi_awvalid && awready_r) begin
        awready_r <= 1'b0;
        aw_hold_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (commit) begin
        aw_hold_r <= 1'b0;
      end else if (!aw_hold_r && !bvalid_r) begin
        awready_r <= 1'b1;
      end
    end
  end

  // Write data channel, taken independently of the address
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wready_r <= 1'b0;
      w_hold_r <= 1'b0;
      wdata_r  <= 8'h00;
      wstrb0_r <= 1'b0;
    end else if (ce) begin
      if (s_axi_wvalid && wready_r) begin
        wready_r <= 1'b0;
        w_hold_r <= 1'b1;
        wdata_r  <= s_axi_wdata[7:0];
        wstrb0_r <= s_axi_wstrb[0];
      end else if (commit) begin
        w_hold_r <= 1'b0;
      end else if (!w_hold_r && !bvalid_r) begin
        wready_r <= 1'b1;
      end
    end
  end

  // Write response; unmapped offsets answer SLVERR
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      bvalid_r <= 1'b0;
      bresp_r  <= `SPW_RESP_OKAY;
    end else if (ce) begin
      if (commit) begin
        bvalid_r <= 1'b1;
        if (awaddr_r == `SPW_PAGE_OFF || awaddr_r == `SPW_PW_OFF ||
            awaddr_r == `SPW_PROT_OFF) begin
          bresp_r <= `SPW_RESP_OKAY;
        end else begin
          bresp_r <= `SPW_RESP_SLV;
        end
      end else if (bvalid_r && s_axi_bready) begin
        bvalid_r <= 1'b0;
      end
    end
  end

  // Read mux; write-only fields and reserved bits read as zero
  always_comb begin
    rd_nxt    = 32'h0000_0000;
    rresp_nxt = `SPW_RESP_OKAY;
    case (s_axi_araddr)
      `SPW_PAGE_OFF: begin
        rd_nxt[`SPW_PAGE_MSB:0] = page_r;
      end
      `SPW_PW_OFF: begin
        rd_nxt[1:0]           = gif.mode;
        rd_nxt[`SPW_LOCK_BIT] = gif.locked;
      end
      `SPW_PROT_OFF: begin
        rd_nxt[7:0] = prot_r;
      end
      default: begin
        rresp_nxt = `SPW_RESP_SLV;
      end
    endcase
  end

  // Read channel; one read in flight, data answered the edge after taking
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      arready_r <= 1'b0;
      rvalid_r  <= 1'b0;
      rdata_r   <= 32'h0000_0000;
      rresp_r   <= `SPW_RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && arready_r) begin
        arready_r <= 1'b0;
        rvalid_r  <= 1'b1;
        rdata_r   <= rd_nxt;
        rresp_r   <= rresp_nxt;
      end else if (rvalid_r && s_axi_rready) begin
        rvalid_r <= 1'b0;
      end else if (!rvalid_r) begin
        arready_r <= 1'b1;
      end
    end
  end

  // Active page: direct, save-and-load, or restore from a slot
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      page_r <= 3'(`SPW_PAGE_RST);
    end else if (ce && wr_page) begin
      if (!pg_op[1]) begin
        page_r <= wdata_r[`SPW_PAGE_MSB:0];
      end else if (!pg_op[0]) begin
        page_r <= wdata_r[`SPW_PAGE_MSB:0];
      end else begin
        page_r <= slot_r[nr];
      end
    end
  end

  // Storage slots keep the page an interrupt routine displaced
  for (genvar i = 0; i < 4; i++) begin : g_slot
    always_ff @(posedge ref_clk) begin
      if (rst) begin
        slot_r[i] <= 3'h0;
      end else if (ce && wr_page && pg_op == 2'h2 && nr == 2'(i)) begin
        slot_r[i] <= page_r;
      end
    end
  end

  // Protected bits; a write while locked is answered OKAY but dropped
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      prot_r <= `SPW_PROT_RST;
    end else if (ce && wr_prot && !gif.locked) begin
      prot_r <= wdata_r;
    end
  end

  a_page_direct: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && wr_page && !pg_op[1]) |=> page_r == $past(wdata_r[2:0]))
    else $error("direct page write not taken");

  a_page_save: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && wr_page && pg_op == 2'h2) |=>
      (page_r == $past(wdata_r[2:0])) && (slot_r[$past(nr)] == $past(page_r)))
    else $error("save and load failed");

  a_page_restore: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && wr_page && pg_op == 2'h3) |=> page_r == $past(slot_r[nr]))
    else $error("restore from slot failed");

  a_page_readback: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && s_axi_arvalid && arready_r && s_axi_araddr == 4'h0) |=>
      rvalid_r && rdata_r[7:3] == 5'h00 && rdata_r[2:0] == $past(page_r))
    else $error("page readback wrong");

  a_prot_block: assert property (@(posedge ref_clk) disable iff (rst)
    (wr_prot && gif.locked) |=> $stable(prot_r))
    else $error("protected bits written while locked");

  a_page_hold: assert property (@(posedge ref_clk) disable iff (rst)
    !(ce && wr_page) |=> $stable(page_r))
    else $error("page changed without a write");

  a_bus_resp: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && commit) |=> bvalid_r ##0 (!aw_hold_r && !w_hold_r))
    else $error("write not answered after commit");
endmodule

// ### pkg/spw_defs.svh
`ifndef SPW_DEFS_SVH
`define SPW_DEFS_SVH

// Register byte offsets
`define SPW_PAGE_OFF   4'h0
`define SPW_PW_OFF     4'h4
`define SPW_PROT_OFF   4'h8

// Page register fields
`define SPW_PAGE_MSB   2
`define SPW_RSVD_BIT   3
`define SPW_SLOT_LSB   4
`define SPW_PGOP_LSB   6
`define SPW_PAGE_RST   8'h00

// Password register fields
`define SPW_MODE_LSB   0
`define SPW_LOCK_BIT   2
`define SPW_PASS_LSB   3
`define SPW_PW_RST     8'h07
`define SPW_MODE_RST   2'h3
`define SPW_MODE_OFF   2'h0
`define SPW_CODE_MODE  5'h18
`define SPW_CODE_OPEN  5'h13
`define SPW_CODE_CLOSE 5'h15

// Protected register fields
`define SPW_NDIVIDER_LSB 0
`define SPW_KDIVIDER_BIT 4
`define SPW_WDT_BIT      5
`define SPW_PWRDN_BIT    6
`define SPW_SLOWDN_BIT   7
`define SPW_PROT_RST   8'h00

// Open window length in core clocks
`define SPW_OPEN_CYC   32

// Bus responses
`define SPW_RESP_OKAY  2'h0
`define SPW_RESP_SLV   2'h2

`endif

// ### pkg/spw_pkg.sv
package spw_pkg;
  typedef logic [2:0]  spw_page_t;
  typedef logic [1:0]  spw_mode_t;
  typedef logic [7:0]  spw_byte_t;
  typedef logic [3:0]  spw_addr_t;
  typedef logic [31:0] spw_data_t;
  typedef logic [4:0]  spw_code_t;
endpackage

// ### pkg/spw_gate_if.sv
`timescale 1ns/1ns
interface spw_gate_if;
  import spw_pkg::*;
  logic      wr;
  spw_byte_t wdata;
  spw_mode_t mode;
  logic      locked;
  modport gate (input wr, input wdata, output mode, output locked);
  modport core (output wr, output wdata, input mode, input locked);
endinterface

// ### rtl/spw_gate.sv
`timescale 1ns/1ns
`include "spw_defs.svh"
module spw_gate (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  spw_gate_if.gate g
);
  import spw_pkg::*;

  spw_mode_t  mode_r;
  spw_mode_t  mode_nxt;
  logic       open_r;
  logic       open_nxt;
  logic [4:0] cnt_r;
  logic [4:0] cnt_nxt;
  logic       locked_r;
  logic       locked_nxt;
  spw_code_t  pass;
  logic [5:0] age_r;

  assign pass     = g.wdata[7:`SPW_PASS_LSB];
  assign g.mode   = mode_r;
  assign g.locked = locked_r;

  // Window countdown first, so a fresh open code overrides expiry
  always_comb begin
    mode_nxt = mode_r;
    open_nxt = open_r;
    cnt_nxt  = cnt_r;
    if (open_r) begin
      if (cnt_r == 5'h0) begin
        open_nxt = 1'b0;
      end else begin
        cnt_nxt = cnt_r - 5'h1;
      end
    end
    if (g.wr) begin
      case (pass)
        `SPW_CODE_MODE: begin
          mode_nxt = g.wdata[1:`SPW_MODE_LSB];
        end
        `SPW_CODE_OPEN: begin
          if (mode_r != `SPW_MODE_OFF) begin
            open_nxt = 1'b1;
            cnt_nxt  = 5'(`SPW_OPEN_CYC - 1);
          end
        end
        `SPW_CODE_CLOSE: begin
          open_nxt = 1'b0;
        end
        default: begin
        end
      endcase
    end
    // Mode 00 leaves everything writable
    locked_nxt = (mode_nxt != `SPW_MODE_OFF) && !open_nxt;
  end

  // Gate state, frozen while the clock enable is low
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mode_r   <= `SPW_MODE_RST;
      open_r   <= 1'b0;
      cnt_r    <= 5'h0;
      locked_r <= 1'b1;
    end else if (ce) begin
      mode_r   <= mode_nxt;
      open_r   <= open_nxt;
      cnt_r    <= cnt_nxt;
      locked_r <= locked_nxt;
    end
  end

  // Independent age of the open window, read only by checks
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      age_r <= 6'h00;
    end else if (ce) begin
      if (g.wr && pass == `SPW_CODE_OPEN) begin
        age_r <= 6'h00;
      end else if (open_r) begin
        age_r <= age_r + 6'h01;
      end
    end
  end

  a_gate_open: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && g.wr && pass == `SPW_CODE_OPEN) |=> !locked_r)
    else $error("open code did not unlock");

  a_gate_close: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && g.wr && pass == `SPW_CODE_CLOSE) |=> (locked_r == (mode_r != 2'h0)))
    else $error("close code did not lock");

  a_mode_guard: assert property (@(posedge ref_clk) disable iff (rst)
    (ce && !(g.wr && pass == `SPW_CODE_MODE)) |=> $stable(mode_r))
    else $error("mode changed without mode code");

  a_gate_timeout: assert property (@(posedge ref_clk) disable iff (rst)
    open_r |-> age_r < 6'd32)
    else $error("open window longer than 32 cycles");

  a_lock_status: assert property (@(posedge ref_clk) disable iff (rst)
    (mode_r == 2'h0) |-> !locked_r)
    else $error("disabled scheme shows locked");
endmodule

// ### verif/tb_top.sv
`timescale 1ns/1ns
`include "spw_defs.svh"
module tb_top;
  import spw_pkg::*;
  logic ref_clk, rst, ce;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  spw_addr_t awaddr, araddr;
  spw_data_t wdata, rdata;
  logic [3:0] wstrb, n_div;
  logic [1:0] bresp, rresp;
  spw_page_t page;
  logic k_div, wdt, pwr_dn, slow_dn, locked;
  int err_total = 0, checked = 0, run = 0, last_run = 0;
  logic [31:0] d;
  logic [1:0] r;
  wire [7:0] prot_o = {slow_dn, pwr_dn, wdt, k_div, n_div};

  spw_top u_spw_top (.ref_clk(ref_clk), .rst(rst), .ce(ce),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .active_page(page), .clock_n_divider(n_div), .clock_k_divider(k_div),
    .watchdog_enable_bit(wdt), .power_down_enable(pwr_dn), .slow_down_enable(slow_dn),
    .prot_locked(locked));

  // Clock at 4 ns period
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Length of each unlocked stretch, latched when the gate locks again
  always @(posedge ref_clk) begin
    if (locked === 1'b0) run <= run + 1;
    else begin
      if (run != 0) last_run <= run;
      run <= 0;
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (err_total == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Write: AW and W offered together, each dropped when taken, bready held until bvalid
  task automatic wr(input spw_addr_t a, input logic [7:0] v, input logic [3:0] s,
                    output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge ref_clk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= {24'h00_0000, v};
    wstrb   <= s;
    bready  <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
      n++;
      if (n > 100) begin
        err_total++;
        break;
      end
    end
    resp = bresp;
    bready <= 1'b0;
  endtask

  task automatic rd(input spw_addr_t a, output logic [31:0] v, output logic [1:0] resp);
    int n;
    n = 0;
    @(posedge ref_clk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    forever begin
      @(posedge ref_clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
      n++;
      if (n > 100) begin
        err_total++;
        break;
      end
    end
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask

  task automatic wr_ok(input spw_addr_t a, input logic [7:0] v);
    wr(a, v, 4'h1, r);
    chk(r, `SPW_RESP_OKAY);
  endtask

  task automatic rd_chk(input spw_addr_t a, input logic [31:0] e);
    rd(a, d, r);
    chk(d, e);
  endtask

  task automatic t_reset();
    rd_chk(`SPW_PAGE_OFF, 32'h0000_0000);
    rd_chk(`SPW_PW_OFF, 32'h0000_0007);
    rd_chk(`SPW_PROT_OFF, 32'h0000_0000);
    chk(locked, 1'b1);
    rd(4'hC, d, r);
    chk(r, `SPW_RESP_SLV);
    wr(4'hC, 8'hFF, 4'h1, r);
    chk(r, `SPW_RESP_SLV);
  endtask

  task automatic t_page();
    wr_ok(`SPW_PAGE_OFF, 8'h35); // Operation 00, slot 3, reserved bit kept 0
    chk(page, 3'h5);
    rd_chk(`SPW_PAGE_OFF, 32'h0000_0005);
    wr_ok(`SPW_PAGE_OFF, 8'h92); // Save 5 in slot 1, load 2
    chk(page, 3'h2);
    wr_ok(`SPW_PAGE_OFF, 8'hA6); // Save 2 in slot 2, load 6
    wr_ok(`SPW_PAGE_OFF, 8'hD7); // Restore slot 1, page bits ignored
    chk(page, 3'h5);
    wr_ok(`SPW_PAGE_OFF, 8'hE1);
    chk(page, 3'h2);
    wr_ok(`SPW_PAGE_OFF, 8'hF7); // Slot 3 never saved by the op 00 write
    chk(page, 3'h0);
    wr(`SPW_PAGE_OFF, 8'h04, 4'h0, r); // Lane 0 strobe off stores nothing
    chk(page, 3'h0);
    chk(r, `SPW_RESP_OKAY);
    wr_ok(`SPW_PAGE_OFF, 8'h01);
    wr_ok(`SPW_PAGE_OFF, 8'h83); // Save 1 in slot 0, load 3
    chk(page, 3'h3);
    wr_ok(`SPW_PAGE_OFF, 8'hC0); // Restore slot 0
    chk(page, 3'h1);
  endtask

  task automatic t_gate();
    wr_ok(`SPW_PROT_OFF, 8'hFF);
    chk(prot_o, 8'h00);
    wr_ok(`SPW_PW_OFF, 8'h98); // Open, mode bits written as 00
    rd_chk(`SPW_PW_OFF, 32'h0000_0003);
    wr_ok(`SPW_PW_OFF, 8'h10); // Unknown code
    chk(locked, 1'b0);
    wr_ok(`SPW_PROT_OFF, 8'hA5);
    chk(prot_o, 8'hA5);
    wr_ok(`SPW_PW_OFF, 8'hA8);
    rd_chk(`SPW_PW_OFF, 32'h0000_0007);
    wr_ok(`SPW_PROT_OFF, 8'h5A);
    chk(prot_o, 8'hA5);
    wr_ok(`SPW_PW_OFF, 8'h52);
    rd_chk(`SPW_PW_OFF, 32'h0000_0007);
  endtask

  task automatic wait_lock();
    int n;
    for (n = 0; n < 200 && locked !== 1'b1; n++) @(posedge ref_clk);
    repeat (2) @(posedge ref_clk);
  endtask

  task automatic t_window();
    wr_ok(`SPW_PW_OFF, 8'h98);
    wait_lock();
    chk(last_run, 32);
    wr_ok(`SPW_PW_OFF, 8'h98);
    repeat (20) @(posedge ref_clk);
    wr_ok(`SPW_PW_OFF, 8'h98);
    repeat (27) @(posedge ref_clk);
    chk(locked, 1'b0);
    wait_lock();
    chk(last_run > 52, 1'b1);
  endtask

  // Clock enable low halts the window count, so the gate must outlive it
  task automatic t_freeze();
    wr_ok(`SPW_PW_OFF, 8'h98);
    ce <= 1'b0;
    repeat (40) @(posedge ref_clk);
    chk(locked, 1'b0);
    ce <= 1'b1;
    wait_lock();
    chk(locked, 1'b1);
  endtask

  task automatic t_mode();
    wr_ok(`SPW_PW_OFF, 8'hC0); // Mode 00
    rd_chk(`SPW_PW_OFF, 32'h0000_0000);
    wr_ok(`SPW_PROT_OFF, 8'h3C);
    chk(prot_o, 8'h3C);
    wr_ok(`SPW_PW_OFF, 8'hC1); // Mode 01 keeps the scheme on
    wr_ok(`SPW_PW_OFF, 8'hA8);
    rd_chk(`SPW_PW_OFF, 32'h0000_0005);
    wr_ok(`SPW_PROT_OFF, 8'h00);
    chk(prot_o, 8'h3C);
    wr_ok(`SPW_PW_OFF, 8'h98);
    chk(locked, 1'b0);
    wr_ok(`SPW_PW_OFF, 8'hC3);
    wr_ok(`SPW_PW_OFF, 8'hA8);
    rd_chk(`SPW_PW_OFF, 32'h0000_0007);
  endtask

  // Watchdog sized well past the whole sequence
  initial begin
    #80000;
    err_total++;
    final_report();
  end

  initial begin
    rst = 1'b1;
    ce = 1'b1;
    awvalid = 1'b0;
    wvalid = 1'b0;
    bready = 1'b0;
    arvalid = 1'b0;
    rready = 1'b0;
    awaddr = 4'h0;
    araddr = 4'h0;
    wdata = 32'h0000_0000;
    wstrb = 4'h0;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    t_reset();
    t_page();
    t_gate();
    t_window();
    t_freeze();
    t_mode();
    final_report();
  end
endmodule
